// ==== rtl/mcif_pkg.sv ====
// Package of constants and types for the bank-four status information fields
package mcif_pkg;
  localparam int STAT_W = 64;
  localparam int CNT_LO = 32;
  localparam int FMT_LO = 40;
  localparam int SYN_LO = 44;
  localparam int SYNV_BIT = 52;
  localparam int THR_LO = 53;
  localparam int MSC_LO = 16;
  localparam int MISC_INFO_VALID_BIT = 59;
  localparam int UC_BIT = 61;
  localparam int VAL_BIT = 63;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [15:0] L3_TYPE_CODE = 16'h010b;
  localparam logic [10:0] L3_FIXED = 11'h100;
  localparam logic [1:0] L3_RSVD = 2'h0;
  typedef enum logic [1:0] {
    MCIF_THR_NONE = 2'h0,
    MCIF_THR_GREEN = 2'h1,
    MCIF_THR_YELLOW = 2'h2
  } mcif_thr_t;
  typedef enum logic [2:0] {
    MCIF_L3_NONE = 3'h0,
    MCIF_L3_MULTI_CE = 3'h1,
    MCIF_L3_MULTI_UE = 3'h2,
    MCIF_L3_MULTI_HIT = 3'h3,
    MCIF_L3_NONE_ALT = 3'h4,
    MCIF_L3_ONE_CE = 3'h5,
    MCIF_L3_ONE_UE = 3'h6,
    MCIF_L3_MIXED = 3'h7
  } mcif_l3_t;
endpackage : mcif_pkg

// ==== rtl/mcif_l3_code.sv ====
// L3 way-status encoder producing the three-bit L3 error code
`timescale 1ns/10ps
`default_nettype none
module mcif_l3_code #(
  parameter int WAYS = 8
) (
  input wire logic [WAYS-1:0] ce_ways,
  input wire logic [WAYS-1:0] ue_ways,
  input wire logic [WAYS-1:0] hit_ways,
  output var mcif_pkg::mcif_l3_t code
);
  import mcif_pkg::*;

  initial begin
    if (WAYS < 2) $error("mcif_l3_code needs at least two ways");
  end

  // Classify each vector as none, one, or several
  function automatic logic [1:0] classify(input logic [WAYS-1:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v != '0) r = ((v & (v - 1'b1)) != '0) ? 2'h2 : 2'h1;
    return r;
  endfunction : classify

  wire logic [1:0] ce_cls = classify(ce_ways);
  wire logic [1:0] ue_cls = classify(ue_ways);
  wire logic [1:0] hit_cls = classify(hit_ways);

  // Priority: mixed, multi hit, ue, ce, none
  always_comb begin
    if (ce_cls != 2'h0 && ue_cls != 2'h0) code = MCIF_L3_MIXED;
    else if (hit_cls == 2'h2) code = MCIF_L3_MULTI_HIT;
    else if (ue_cls == 2'h2) code = MCIF_L3_MULTI_UE;
    else if (ue_cls == 2'h1) code = MCIF_L3_ONE_UE;
    else if (ce_cls == 2'h2) code = MCIF_L3_MULTI_CE;
    else if (ce_cls == 2'h1) code = MCIF_L3_ONE_CE;
    else code = MCIF_L3_NONE;
  end
endmodule : mcif_l3_code
`default_nettype wire

// ==== rtl/mcif_info_fields.sv ====
// Bank-four status word: shared information fields and L3 error code
`timescale 1ns/10ps
`default_nettype none
module mcif_info_fields #(
  parameter int WAYS = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WARM_RST_N,
  input wire logic LOG_EVT,
  input wire logic LOG_CORRECTED,
  input wire logic LOG_L3,
  input wire logic [15:0] LOG_OTHER_CODE,
  input wire logic [15:0] LOG_OTHER_MSC,
  input wire logic [WAYS-1:0] CE_WAYS,
  input wire logic [WAYS-1:0] UE_WAYS,
  input wire logic [WAYS-1:0] HIT_WAYS,
  input wire logic SYN_SUPPLIED,
  input wire logic [7:0] SYNDROME,
  input wire logic MISC_HAS_INFO,
  input wire logic [1:0] MISC_FMT,
  input wire logic THR_TRACKED,
  input wire logic THR_ABOVE,
  input wire logic CLR_VALID,
  output logic [mcif_pkg::STAT_W-1:0] BANK4_ERROR_STATUS
);
  import mcif_pkg::*;

  initial begin
    if (WAYS < 2 || WAYS > 64) $error("WAYS out of range");
  end

  // ****************************************
  // Registers and next values
  // ****************************************
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] fmt_r, fmt_nxt;
  logic [7:0] syn_r, syn_nxt;
  logic synv_r, synv_nxt;
  logic [1:0] thr_r, thr_nxt;
  logic [15:0] msc_r, msc_nxt;
  logic [15:0] code_r, code_nxt;
  logic misc_info_valid_r, misc_info_valid_nxt;
  logic uc_r, uc_nxt;
  logic val_r, val_nxt;
  mcif_l3_t l3_code;

  // ****************************************
  // L3 code encoder
  // ****************************************
  mcif_l3_code #(.WAYS(WAYS)) u_l3 (
    .ce_ways(CE_WAYS),
    .ue_ways(UE_WAYS),
    .hit_ways(HIT_WAYS),
    .code(l3_code)
  );

  // Correctable event counter, saturating
  wire logic ce_evt = LOG_EVT && LOG_CORRECTED;
  assign cnt_nxt = (ce_evt && cnt_r != CNT_MAX) ? cnt_r + 8'h01 : cnt_r;

  // Syndrome capture on correctable ECC events
  wire logic syn_load = ce_evt && SYN_SUPPLIED;
  assign syn_nxt = syn_load ? SYNDROME : syn_r;
  assign synv_nxt = LOG_EVT ? syn_load : synv_r;

  // Threshold status; code 11 cannot arise
  wire logic [1:0] thr_evt = !THR_TRACKED ? MCIF_THR_NONE :
    (THR_ABOVE ? MCIF_THR_YELLOW : MCIF_THR_GREEN);
  assign thr_nxt = LOG_EVT ? thr_evt : thr_r;

  // Misc format and its valid flag
  assign fmt_nxt = LOG_EVT ? (MISC_HAS_INFO ? MISC_FMT : 2'h0) : fmt_r;
  assign misc_info_valid_nxt = LOG_EVT ? MISC_HAS_INFO : misc_info_valid_r;

  // Error type and model code; L3 uses the fixed layout
  assign msc_nxt = !LOG_EVT ? msc_r :
    LOG_L3 ? {L3_FIXED, L3_RSVD, l3_code} : LOG_OTHER_MSC;
  assign code_nxt = !LOG_EVT ? code_r :
    LOG_L3 ? L3_TYPE_CODE : LOG_OTHER_CODE;
  assign uc_nxt = LOG_EVT ? !LOG_CORRECTED : uc_r;
  // Logging wins over a software clear in the same cycle
  assign val_nxt = LOG_EVT ? 1'b1 : (CLR_VALID ? 1'b0 : val_r);

  // Counter cleared only by cold reset
  always_ff @(posedge CLK) begin
    if (!RST_N) cnt_r <= CNT_RST;
    else cnt_r <= cnt_nxt;
  end

  // Log fields, cleared by cold or warm reset
  always_ff @(posedge CLK) begin
    if (!RST_N || !WARM_RST_N) begin
      fmt_r <= 2'h0;
      syn_r <= 8'h00;
      synv_r <= 1'b0;
      thr_r <= 2'h0;
      msc_r <= 16'h0000;
      code_r <= 16'h0000;
      misc_info_valid_r <= 1'b0;
      uc_r <= 1'b0;
      val_r <= 1'b0;
    end else begin
      fmt_r <= fmt_nxt;
      syn_r <= syn_nxt;
      synv_r <= synv_nxt;
      thr_r <= thr_nxt;
      msc_r <= msc_nxt;
      code_r <= code_nxt;
      misc_info_valid_r <= misc_info_valid_nxt;
      uc_r <= uc_nxt;
      val_r <= val_nxt;
    end
  end

  // Status word assembly, reserved bits tied low
  always_comb begin
    BANK4_ERROR_STATUS = '0;
    BANK4_ERROR_STATUS[15:0] = code_r;
    BANK4_ERROR_STATUS[MSC_LO +: 16] = msc_r;
    BANK4_ERROR_STATUS[CNT_LO +: 8] = cnt_r;
    BANK4_ERROR_STATUS[FMT_LO +: 2] = fmt_r;
    BANK4_ERROR_STATUS[SYN_LO +: 8] = syn_r;
    BANK4_ERROR_STATUS[SYNV_BIT] = synv_r;
    BANK4_ERROR_STATUS[THR_LO +: 2] = thr_r;
    BANK4_ERROR_STATUS[MISC_INFO_VALID_BIT] = misc_info_valid_r;
    BANK4_ERROR_STATUS[UC_BIT] = uc_r;
    BANK4_ERROR_STATUS[VAL_BIT] = val_r;
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_ce_log;
    ce_evt && cnt_r != CNT_MAX;
  endsequence

  AST_CNT_INC: assert property (@(posedge CLK) disable iff (!RST_N)
    s_ce_log |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("counter did not advance");
  AST_CNT_SAT: assert property (@(posedge CLK) disable iff (!RST_N)
    cnt_r == CNT_MAX |=> cnt_r == CNT_MAX)
    else $error("counter left saturation");
  AST_CNT_WARM: assert property (@(posedge CLK) disable iff (!RST_N)
    !WARM_RST_N && !ce_evt |=> $stable(cnt_r))
    else $error("warm reset changed counter");
  AST_SYN: assert property (@(posedge CLK) disable iff (!RST_N)
    syn_load && WARM_RST_N |=> BANK4_ERROR_STATUS[51:44] == $past(SYNDROME)
      && BANK4_ERROR_STATUS[SYNV_BIT])
    else $error("syndrome not captured");
  AST_THR: assert property (@(posedge CLK) disable iff (!RST_N)
    BANK4_ERROR_STATUS[54:53] != 2'h3)
    else $error("reserved threshold code");
  AST_RSVD: assert property (@(posedge CLK) disable iff (!RST_N)
    BANK4_ERROR_STATUS[43:42] == 2'h0 && BANK4_ERROR_STATUS[56:55] == 2'h0)
    else $error("reserved bits nonzero");
  AST_VAL: assert property (@(posedge CLK) disable iff (!RST_N)
    LOG_EVT && WARM_RST_N |=> BANK4_ERROR_STATUS[VAL_BIT])
    else $error("valid flag not set by a log");
  AST_UC: assert property (@(posedge CLK) disable iff (!RST_N)
    LOG_EVT && WARM_RST_N |=> uc_r == !$past(LOG_CORRECTED))
    else $error("uncorrected flag wrong");
  AST_L3: assert property (@(posedge CLK) disable iff (!RST_N)
    LOG_EVT && LOG_L3 && WARM_RST_N |=> BANK4_ERROR_STATUS[31:19] == 13'h0400
      && BANK4_ERROR_STATUS[15:0] == 16'h010b)
    else $error("L3 code layout wrong");

  // ****************************************
  // Field checks against the log inputs
  // ****************************************
  // L3 log and a lookup with at most one tag hit
  wire logic l3_log = LOG_EVT && WARM_RST_N && LOG_L3;
  wire logic hit_low = $onehot0(HIT_WAYS);

  // Nothing that may change the word this cycle
  sequence s_quiet;
    !LOG_EVT && !CLR_VALID && WARM_RST_N;
  endsequence

  // Logs with and without misc information
  sequence s_misc_log;
    LOG_EVT && WARM_RST_N && MISC_HAS_INFO;
  endsequence

  sequence s_nomisc_log;
    LOG_EVT && WARM_RST_N && !MISC_HAS_INFO;
  endsequence

  // Log that brings no syndrome along
  sequence s_nosyn_log;
    LOG_EVT && WARM_RST_N && !syn_load;
  endsequence

  // Logs by threshold tracking state
  sequence s_untracked_log;
    LOG_EVT && WARM_RST_N && !THR_TRACKED;
  endsequence

  sequence s_green_log;
    LOG_EVT && WARM_RST_N && THR_TRACKED && !THR_ABOVE;
  endsequence

  sequence s_yellow_log;
    LOG_EVT && WARM_RST_N && THR_TRACKED && THR_ABOVE;
  endsequence

  // Software clear with no log beside it
  sequence s_sw_clear;
    CLR_VALID && !LOG_EVT && WARM_RST_N;
  endsequence

  // Valid entry with nothing to clear it
  sequence s_val_held;
    val_r && !CLR_VALID && WARM_RST_N;
  endsequence

  // Log of an error that is not an L3 error
  sequence s_other_log;
    LOG_EVT && WARM_RST_N && !LOG_L3;
  endsequence

  // L3 logs sorted by their way vectors, in priority order
  sequence s_l3_mixed;
    l3_log && CE_WAYS != '0 && UE_WAYS != '0;
  endsequence

  sequence s_l3_hit;
    l3_log && !hit_low && (CE_WAYS == '0 || UE_WAYS == '0);
  endsequence

  sequence s_l3_multi_ue;
    l3_log && hit_low && CE_WAYS == '0 && $countones(UE_WAYS) > 1;
  endsequence

  sequence s_l3_one_ue;
    l3_log && hit_low && CE_WAYS == '0 && $onehot(UE_WAYS);
  endsequence

  sequence s_l3_multi_ce;
    l3_log && hit_low && UE_WAYS == '0 && $countones(CE_WAYS) > 1;
  endsequence

  sequence s_l3_one_ce;
    l3_log && hit_low && UE_WAYS == '0 && $onehot(CE_WAYS);
  endsequence

  sequence s_l3_clean;
    l3_log && hit_low && CE_WAYS == '0 && UE_WAYS == '0;
  endsequence

  // Counter moves only with a correctable log
  AST_CNT_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    !ce_evt |=> $stable(cnt_r))
    else $error("counter moved without an event");

  // First correctable event reads as one
  AST_CNT_FIRST: assert property (@(posedge CLK) disable iff (!RST_N)
    ce_evt && cnt_r == CNT_RST |=> BANK4_ERROR_STATUS[39:32] == 8'h01)
    else $error("first event count wrong");

  // Misc format follows the log when misc information is present
  AST_FMT_SET: assert property (@(posedge CLK) disable iff (!RST_N)
    s_misc_log |=> BANK4_ERROR_STATUS[41:40] == $past(MISC_FMT)
      && BANK4_ERROR_STATUS[MISC_INFO_VALID_BIT])
    else $error("misc format not logged");

  // No misc information, no valid flag and a zero format
  AST_FMT_NONE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_nomisc_log |=> BANK4_ERROR_STATUS[41:40] == 2'h0
      && !BANK4_ERROR_STATUS[MISC_INFO_VALID_BIT])
    else $error("misc flag set without information");

  // Syndrome valid bit drops on a log without syndrome
  AST_SYN_NONE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_nosyn_log |=> !BANK4_ERROR_STATUS[SYNV_BIT])
    else $error("syndrome valid without syndrome");

  // Threshold code per tracking inputs
  AST_THR_NONE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_untracked_log |=> BANK4_ERROR_STATUS[54:53] == 2'h0)
    else $error("threshold code not none");
  AST_THR_GREEN: assert property (@(posedge CLK) disable iff (!RST_N)
    s_green_log |=> BANK4_ERROR_STATUS[54:53] == 2'h1)
    else $error("threshold code not green");
  AST_THR_YELLOW: assert property (@(posedge CLK) disable iff (!RST_N)
    s_yellow_log |=> BANK4_ERROR_STATUS[54:53] == 2'h2)
    else $error("threshold code not yellow");

  // Hardware never drops the valid flag by itself
  AST_VAL_KEEP: assert property (@(posedge CLK) disable iff (!RST_N)
    s_val_held |=> val_r)
    else $error("valid flag lost");

  // Software clear takes effect when no log competes
  AST_VAL_CLR: assert property (@(posedge CLK) disable iff (!RST_N)
    s_sw_clear |=> !BANK4_ERROR_STATUS[VAL_BIT])
    else $error("valid flag not cleared");

  // Non-L3 logs carry their codes unchanged
  AST_OTHER: assert property (@(posedge CLK) disable iff (!RST_N)
    s_other_log |=> BANK4_ERROR_STATUS[31:0] ==
      {$past(LOG_OTHER_MSC), $past(LOG_OTHER_CODE)})
    else $error("non-L3 codes not logged");

  // Quiet cycle leaves the whole word alone
  AST_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    s_quiet |=> $stable(BANK4_ERROR_STATUS))
    else $error("status word changed while quiet");

  // Warm reset leaves only the count standing
  AST_WARM: assert property (@(posedge CLK) disable iff (!RST_N)
    !WARM_RST_N |=> BANK4_ERROR_STATUS[63:40] == '0
      && BANK4_ERROR_STATUS[31:0] == '0)
    else $error("warm reset left fields set");

  // Cold reset clears the whole word
  AST_COLD: assert property (@(posedge CLK)
    !RST_N |=> BANK4_ERROR_STATUS == '0)
    else $error("cold reset left word set");

  // L3 code against the way vectors
  AST_L3_MIXED: assert property (@(posedge CLK) disable iff (!RST_N)
    s_l3_mixed |=> BANK4_ERROR_STATUS[18:16] == 3'h7)
    else $error("L3 mixed code wrong");

  AST_L3_HIT: assert property (@(posedge CLK) disable iff (!RST_N)
    s_l3_hit |=> BANK4_ERROR_STATUS[18:16] == 3'h3)
    else $error("L3 multi hit code wrong");

  AST_L3_MULTI_UE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_l3_multi_ue |=> BANK4_ERROR_STATUS[18:16] == 3'h2)
    else $error("L3 multi uncorrectable code wrong");

  AST_L3_ONE_UE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_l3_one_ue |=> BANK4_ERROR_STATUS[18:16] == 3'h6)
    else $error("L3 one uncorrectable code wrong");

  AST_L3_MULTI_CE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_l3_multi_ce |=> BANK4_ERROR_STATUS[18:16] == 3'h1)
    else $error("L3 multi correctable code wrong");

  AST_L3_ONE_CE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_l3_one_ce |=> BANK4_ERROR_STATUS[18:16] == 3'h5)
    else $error("L3 one correctable code wrong");

  AST_L3_CLEAN: assert property (@(posedge CLK) disable iff (!RST_N)
    s_l3_clean |=> BANK4_ERROR_STATUS[18:16] inside {3'h0, 3'h4})
    else $error("L3 no error code wrong");
endmodule : mcif_info_fields
`default_nettype wire

// ==== dv/mcif_info_fields_test.sv ====
// Self-checking bench for the status word information fields
`timescale 1ns/10ps
`default_nettype none
module mcif_info_fields_test;
  import mcif_pkg::*;
  // ****************************
  // Stimulus and expected state
  // ****************************
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic WARM_RST_N = 1'b1;
  logic LOG_EVT = 1'b0;
  logic LOG_CORRECTED = 1'b0;
  logic LOG_L3 = 1'b0;
  logic [15:0] LOG_OTHER_CODE = 16'h0400;
  logic [15:0] LOG_OTHER_MSC = 16'hc002;
  logic [7:0] CE_WAYS = 8'h00;
  logic [7:0] UE_WAYS = 8'h00;
  logic [7:0] HIT_WAYS = 8'h00;
  logic SYN_SUPPLIED = 1'b0;
  logic [7:0] SYNDROME = 8'h00;
  logic MISC_HAS_INFO = 1'b0;
  logic [1:0] MISC_FMT = 2'h0;
  logic THR_TRACKED = 1'b0;
  logic THR_ABOVE = 1'b0;
  logic CLR_VALID = 1'b0;
  logic [63:0] BANK4_ERROR_STATUS;
  logic [7:0] e_cnt = 8'h00;
  logic [7:0] e_syn = 8'h00;
  logic [63:0] ew = 64'h0;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  // Undriven flag bits left out; threshold too when uncorrected
  localparam logic [63:0] MK = 64'ha9ff_ffff_ffff_ffff;
  localparam logic [63:0] MKU = 64'ha99f_ffff_ffff_ffff;
  // L3 way patterns, corrected flags and codes
  localparam logic [6:0] CO_V = 7'b0010011;
  localparam logic [2:0] LC_T [7] =
    '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  localparam logic [7:0] CE_T [7] =
    '{8'h0, 8'h3, 8'h0, 8'h0, 8'h4, 8'h0, 8'h10};
  localparam logic [7:0] UE_T [7] =
    '{8'h0, 8'h0, 8'hc, 8'h0, 8'h0, 8'h20, 8'h1};
  localparam logic [7:0] HT_T [7] =
    '{8'h0, 8'h0, 8'h0, 8'h30, 8'h0, 8'h0, 8'h0};

  mcif_info_fields #(.WAYS(8)) mcif_info_fields_inst (
    .CLK(CLK), .RST_N(RST_N), .WARM_RST_N(WARM_RST_N), .LOG_EVT(LOG_EVT),
    .LOG_CORRECTED(LOG_CORRECTED), .LOG_L3(LOG_L3),
    .LOG_OTHER_CODE(LOG_OTHER_CODE), .LOG_OTHER_MSC(LOG_OTHER_MSC),
    .CE_WAYS(CE_WAYS), .UE_WAYS(UE_WAYS), .HIT_WAYS(HIT_WAYS),
    .SYN_SUPPLIED(SYN_SUPPLIED), .SYNDROME(SYNDROME),
    .MISC_HAS_INFO(MISC_HAS_INFO), .MISC_FMT(MISC_FMT),
    .THR_TRACKED(THR_TRACKED), .THR_ABOVE(THR_ABOVE),
    .CLR_VALID(CLR_VALID), .BANK4_ERROR_STATUS(BANK4_ERROR_STATUS)
  );

  // Clock and hang guard
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [63:0] e, input logic [63:0] g,
    input logic [63:0] m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask : chk

  // One logged event, then the word one cycle later
  task automatic lg(input logic co, input logic l3, input logic [2:0] lc,
    input logic [7:0] ce, input logic [7:0] ue, input logic [7:0] ht,
    input logic ss, input logic [7:0] sy, input logic [4:0] mt);
    logic [1:0] th;
    @(negedge CLK);
    LOG_EVT = 1'b1;
    LOG_CORRECTED = co;
    LOG_L3 = l3;
    CE_WAYS = ce;
    UE_WAYS = ue;
    HIT_WAYS = ht;
    SYN_SUPPLIED = ss;
    SYNDROME = sy;
    {MISC_HAS_INFO, MISC_FMT, THR_TRACKED, THR_ABOVE} = mt;
    @(negedge CLK);
    LOG_EVT = 1'b0;
    if (co) e_cnt = (e_cnt == 8'hff) ? e_cnt : e_cnt + 8'h01;
    if (ss && co) e_syn = sy;
    th = mt[1] ? (mt[0] ? 2'h2 : 2'h1) : 2'h0;
    ew = {1'b1, 1'b0, !co, 1'b0, mt[4], 4'h0, th, ss && co, e_syn, 2'h0,
      mt[3:2] & {2{mt[4]}}, e_cnt, l3 ? {11'h100, 2'h0, lc} : LOG_OTHER_MSC,
      l3 ? 16'h010b : LOG_OTHER_CODE};
    chk(ew, BANK4_ERROR_STATUS, co ? MK : MKU);
  endtask : lg

  task automatic t_cold;
    @(negedge CLK);
    RST_N = 1'b0;
    repeat (2) @(negedge CLK);
    RST_N = 1'b1;
    e_cnt = 8'h00;
    e_syn = 8'h00;
    chk(64'h0, BANK4_ERROR_STATUS, '1);
    $display("test cold reset done");
  endtask : t_cold

  task automatic t_l3;
    logic [4:0] mt;
    for (int i = 0; i < 7; i++) begin
      mt = {i[0], i[1:0], i[2] | i[1], i[0]};
      lg(CO_V[i], 1'b1, LC_T[i], CE_T[i], UE_T[i], HT_T[i],
        1'b0, 8'h0, mt);
    end
    $display("test l3 codes done");
  endtask : t_l3

  task automatic t_syn;
    lg(1'b1, 1'b0, 3'h0, 8'h0, 8'h0, 8'h0, 1'b1, 8'h5a, 5'b10111);
    lg(1'b1, 1'b0, 3'h0, 8'h0, 8'h0, 8'h0, 1'b0, 8'ha5, 5'b11010);
    lg(1'b0, 1'b0, 3'h0, 8'h0, 8'h0, 8'h0, 1'b0, 8'h00, 5'b01100);
    $display("test syndrome and misc done");
  endtask : t_syn

  // Software clear, then clear and log on one edge
  task automatic t_clr;
    @(negedge CLK);
    CLR_VALID = 1'b1;
    @(negedge CLK);
    ew[63] = 1'b0;
    chk(ew, BANK4_ERROR_STATUS, MKU);
    lg(1'b1, 1'b0, 3'h0, 8'h0, 8'h0, 8'h0, 1'b0, 8'h0, 5'h0);
    CLR_VALID = 1'b0;
    $display("test valid clear done");
  endtask : t_clr

  task automatic t_warm;
    @(negedge CLK);
    WARM_RST_N = 1'b0;
    @(negedge CLK);
    WARM_RST_N = 1'b1;
    e_syn = 8'h00;
    chk({24'h0, e_cnt, 32'h0}, BANK4_ERROR_STATUS, '1);
    $display("test warm reset done");
  endtask : t_warm

  task automatic t_sat;
    repeat (256) lg(1'b1, 1'b0, 3'h0, 8'h0, 8'h0, 8'h0, 1'b0, 8'h0,
      5'h3);
    $display("test counter saturation done");
  endtask : t_sat

  // Main sequence
  initial begin
    repeat (20) @(negedge CLK);
    RST_N = 1'b1;
    t_cold();
    t_l3();
    t_syn();
    t_clr();
    t_warm();
    t_sat();
    t_cold();
    summarize();
  end
endmodule : mcif_info_fields_test
`default_nettype wire
